// file: src/fcd_buf_mem.sv
`timescale 1ns/10ps
// word store for buffered programming; read data registered
module fcd_buf_mem (
    // clock
    input wire logic clk_i,
    input wire logic en_i,
    // write port
    input wire logic we_i,
    input wire logic [fcd_pkg::BUF_AW-1:0] waddr_i,
    input wire logic [fcd_pkg::DW-1:0] wdata_i,
    // read port
    input wire logic [fcd_pkg::BUF_AW-1:0] raddr_i,
    output logic [fcd_pkg::DW-1:0] rdata_o
);
    logic [fcd_pkg::DW-1:0] mem [fcd_pkg::BUF_DEPTH];

    always_ff @(posedge clk_i) begin
        if (en_i) begin
            if (we_i) begin
                mem[waddr_i] <= wdata_i;
            end
            rdata_o <= mem[raddr_i];
        end
    end
endmodule : fcd_buf_mem

// file: src/fcd_host.sv
`timescale 1ns/10ps
// Contract
// - array read: one read cycle returns word
// - F0 write returns device to read
// - 70 at 555, next read gives status
// - 71 at 555 clears status errors
// - word program: AA, 55, A0, data
// - buffered: unlock, 25, count, data words
// - 29 at sector confirms buffer program
// - abort recovery: AA, 55, F0 at 555
// - chip erase: six cycles ending 10
// - sector erase: sixth cycle 30 at sector
// - B0 anywhere suspends erase or program
// - 30 anywhere resumes suspended operation
// - 51 anywhere suspends program only
module fcd_host (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic en_i,
    // command port
    input wire logic cmd_valid_i,
    input fcd_pkg::fcd_op_t cmd_op_i,
    input wire logic [fcd_pkg::AW-1:0] cmd_addr_i,
    input wire logic [fcd_pkg::DW-1:0] cmd_data_i,
    input wire logic [fcd_pkg::CNT_W-1:0] cmd_count_i,
    output logic cmd_ready_o,
    output logic [fcd_pkg::DW-1:0] rdata_o,
    output logic rdata_valid_o,
    // buffer load port
    input wire logic buf_we_i,
    input wire logic [fcd_pkg::BUF_AW-1:0] buf_idx_i,
    input wire logic [fcd_pkg::DW-1:0] buf_wdata_i,
    // flash pins
    output logic [fcd_pkg::AW-1:0] addr_o,
    output logic [fcd_pkg::DW-1:0] dq_o,
    output logic dq_oe_o,
    input wire logic [fcd_pkg::DW-1:0] dq_i,
    output logic ce_n_o,
    output logic we_n_o,
    output logic oe_n_o
);
    typedef enum logic [2:0] {S_IDLE, S_FETCH, S_SETUP, S_WLOW, S_WHIGH, S_RLOW, S_RSAMP} fcd_state_t;

    fcd_state_t state_q, state_d;
    fcd_pkg::fcd_op_t op_q, op_d;
    logic [fcd_pkg::AW-1:0] addr_q, addr_d, pin_addr_d;
    logic [fcd_pkg::DW-1:0] data_q, data_d, dq_d, rdata_d;
    logic [fcd_pkg::CNT_W-1:0] wc_q, wc_d, step_q, step_d, last_q, last_d;
    logic [fcd_pkg::TIM_W-1:0] tim_q, tim_d;
    logic ready_d, rvalid_d, dq_oe_d, ce_n_d, we_n_d, oe_n_d;
    logic [fcd_pkg::DW-1:0] sy1_q, sy2_q, sy3_q;
    logic [fcd_pkg::DW-1:0] mem_rdata;
    logic [fcd_pkg::CNT_W-1:0] slot;
    logic [fcd_pkg::STEP_W-1:0] info;

    // the two unlock cycles shared by the program, buffer abort and erase sequences
    function automatic logic [fcd_pkg::STEP_W-1:0] unlock(input logic second);
        if (second) begin
            unlock = {2'b00, fcd_pkg::A_UNLOCK2, fcd_pkg::D_UNLOCK2};
        end else begin
            unlock = {2'b00, fcd_pkg::A_UNLOCK1, fcd_pkg::D_UNLOCK1};
        end
    endfunction : unlock

    function automatic logic [fcd_pkg::STEP_W-1:0] wr(input logic [fcd_pkg::AW-1:0] a,
                                                       input logic [fcd_pkg::DW-1:0] d);
        wr = {2'b00, a, d};
    endfunction : wr

    // last step index of each sequence
    function automatic logic [fcd_pkg::CNT_W-1:0] last_step(input fcd_pkg::fcd_op_t op,
                                                             input logic [fcd_pkg::CNT_W-1:0] n);
        case (op)
            fcd_pkg::OP_SR_READ: last_step = 9'h001;
            fcd_pkg::OP_PROG: last_step = 9'h003;
            fcd_pkg::OP_BUF_PROG: last_step = fcd_pkg::BUF_HDR_STEPS + n;
            fcd_pkg::OP_BUF_ABORT: last_step = 9'h002;
            fcd_pkg::OP_CHIP_ERASE: last_step = 9'h005;
            fcd_pkg::OP_SECT_ERASE: last_step = 9'h005;
            default: last_step = 9'h000;
        endcase
    endfunction : last_step

    // {is_read, from_buffer, address, data} of step k
    function automatic logic [fcd_pkg::STEP_W-1:0] step_info(input fcd_pkg::fcd_op_t op,
                                                              input logic [fcd_pkg::CNT_W-1:0] k,
                                                              input logic [fcd_pkg::CNT_W-1:0] last,
                                                              input logic [fcd_pkg::AW-1:0] a,
                                                              input logic [fcd_pkg::DW-1:0] d,
                                                              input logic [fcd_pkg::CNT_W-1:0] n);
        logic [fcd_pkg::CNT_W-1:0] slot_k;
        slot_k = k - fcd_pkg::BUF_HDR_STEPS;
        step_info = {2'b10, a, d};
        case (op)
            fcd_pkg::OP_READ: step_info = {2'b10, a, d};
            fcd_pkg::OP_RESET: step_info = wr(a, fcd_pkg::D_RESET);
            fcd_pkg::OP_SR_READ: begin
                if (k == 9'h000) begin
                    step_info = wr(fcd_pkg::A_UNLOCK1, fcd_pkg::D_SR_READ);
                end
            end
            fcd_pkg::OP_SR_CLEAR: step_info = wr(fcd_pkg::A_UNLOCK1, fcd_pkg::D_SR_CLEAR);
            fcd_pkg::OP_PROG: begin
                if (k < 9'h002) begin
                    step_info = unlock(k[0]);
                end else if (k == 9'h002) begin
                    step_info = wr(fcd_pkg::A_UNLOCK1, fcd_pkg::D_PROG);
                end else begin
                    step_info = wr(a, d);
                end
            end
            fcd_pkg::OP_BUF_PROG: begin
                if (k < 9'h002) begin
                    step_info = unlock(k[0]);
                end else if (k == 9'h002) begin
                    step_info = wr(a, fcd_pkg::D_BUF_LOAD);
                end else if (k == 9'h003) begin
                    // the count word carries the number of words less one
                    step_info = wr(a, fcd_pkg::DW'(n - 9'h001));
                end else if (k == last) begin
                    step_info = wr(a, fcd_pkg::D_BUF_CONFIRM);
                end else begin
                    step_info = {2'b01, a + (fcd_pkg::AW)'(slot_k), d};
                end
            end
            fcd_pkg::OP_BUF_ABORT: begin
                if (k < 9'h002) begin
                    step_info = unlock(k[0]);
                end else begin
                    step_info = wr(fcd_pkg::A_UNLOCK1, fcd_pkg::D_RESET);
                end
            end
            fcd_pkg::OP_CHIP_ERASE, fcd_pkg::OP_SECT_ERASE: begin
                if (k == 9'h002) begin
                    step_info = wr(fcd_pkg::A_UNLOCK1, fcd_pkg::D_ERASE_SETUP);
                end else if (k == 9'h005 && op == fcd_pkg::OP_CHIP_ERASE) begin
                    step_info = wr(fcd_pkg::A_UNLOCK1, fcd_pkg::D_CHIP_ERASE);
                end else if (k == 9'h005) begin
                    step_info = wr(a, fcd_pkg::D_SECT_ERASE);
                end else begin
                    step_info = unlock(k == 9'h001 || k == 9'h004);
                end
            end
            fcd_pkg::OP_SUSPEND: step_info = wr(a, fcd_pkg::D_SUSPEND);
            fcd_pkg::OP_RESUME: step_info = wr(a, fcd_pkg::D_RESUME);
            fcd_pkg::OP_PROG_SUSPEND: step_info = wr(a, fcd_pkg::D_PROG_SUSPEND);
            default: step_info = {2'b10, a, d};
        endcase
    endfunction : step_info

    assign slot = step_q - fcd_pkg::BUF_HDR_STEPS;
    assign info = step_info(op_q, step_q, last_q, addr_q, data_q, wc_q);

    fcd_buf_mem u_buf (
        .clk_i(clk_i),
        .en_i(en_i),
        .we_i(buf_we_i),
        .waddr_i(buf_idx_i),
        .wdata_i(buf_wdata_i),
        .raddr_i(slot[fcd_pkg::BUF_AW-1:0]),
        .rdata_o(mem_rdata)
    );

    // dq_i is asynchronous to clk_i
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sy1_q <= 16'h0000;
            sy2_q <= 16'h0000;
            sy3_q <= 16'h0000;
        end else if (en_i) begin
            sy1_q <= dq_i;
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
        end
    end

    always_comb begin
        state_d = state_q;
        op_d = op_q;
        addr_d = addr_q;
        data_d = data_q;
        wc_d = wc_q;
        step_d = step_q;
        last_d = last_q;
        tim_d = tim_q;
        ready_d = cmd_ready_o;
        rdata_d = rdata_o;
        rvalid_d = 1'b0;
        pin_addr_d = addr_o;
        dq_d = dq_o;
        dq_oe_d = dq_oe_o;
        ce_n_d = ce_n_o;
        we_n_d = we_n_o;
        oe_n_d = oe_n_o;
        case (state_q)
            S_IDLE: begin
                if (cmd_valid_i) begin
                    op_d = cmd_op_i;
                    addr_d = cmd_addr_i;
                    data_d = cmd_data_i;
                    wc_d = cmd_count_i;
                    last_d = last_step(cmd_op_i, cmd_count_i);
                    step_d = 9'h000;
                    ready_d = 1'b0;
                    state_d = S_FETCH;
                end
            end
            // spare cycle lets the store present the buffered word
            S_FETCH: state_d = S_SETUP;
            S_SETUP: begin
                pin_addr_d = info[fcd_pkg::STEP_W-3 -: fcd_pkg::AW];
                ce_n_d = 1'b0;
                if (info[fcd_pkg::STEP_W-1]) begin
                    oe_n_d = 1'b0;
                    dq_oe_d = 1'b0;
                    tim_d = fcd_pkg::TIM_W'(fcd_pkg::ACC_CYC + fcd_pkg::SYNC_LAT - 1);
                    state_d = S_RLOW;
                end else begin
                    dq_d = info[fcd_pkg::STEP_W-2] ? mem_rdata : info[fcd_pkg::DW-1:0];
                    dq_oe_d = 1'b1;
                    we_n_d = 1'b0;
                    tim_d = fcd_pkg::TIM_W'(fcd_pkg::WP_CYC - 1);
                    state_d = S_WLOW;
                end
            end
            S_WLOW: begin
                if (tim_q == 8'h00) begin
                    we_n_d = 1'b1;
                    tim_d = fcd_pkg::TIM_W'(fcd_pkg::WPH_CYC - 1);
                    state_d = S_WHIGH;
                end else begin
                    tim_d = tim_q - 8'h01;
                end
            end
            // chip enable and data held through the recovery time
            S_WHIGH: begin
                if (tim_q == 8'h00) begin
                    ce_n_d = 1'b1;
                    dq_oe_d = 1'b0;
                    if (step_q == last_q) begin
                        ready_d = 1'b1;
                        state_d = S_IDLE;
                    end else begin
                        step_d = step_q + 9'h001;
                        state_d = S_FETCH;
                    end
                end else begin
                    tim_d = tim_q - 8'h01;
                end
            end
            S_RLOW: begin
                if (tim_q == 8'h00) begin
                    state_d = S_RSAMP;
                end else begin
                    tim_d = tim_q - 8'h01;
                end
            end
            // wait for two synchronised samples to agree before taking the word
            S_RSAMP: begin
                if (sy2_q == sy3_q) begin
                    rdata_d = sy3_q;
                    rvalid_d = 1'b1;
                    oe_n_d = 1'b1;
                    ce_n_d = 1'b1;
                    if (step_q == last_q) begin
                        ready_d = 1'b1;
                        state_d = S_IDLE;
                    end else begin
                        step_d = step_q + 9'h001;
                        state_d = S_FETCH;
                    end
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= S_IDLE;
            op_q <= fcd_pkg::OP_READ;
            addr_q <= 26'h0000000;
            data_q <= 16'h0000;
            wc_q <= 9'h000;
            step_q <= 9'h000;
            last_q <= 9'h000;
            tim_q <= 8'h00;
            cmd_ready_o <= 1'b1;
            rdata_o <= 16'h0000;
            rdata_valid_o <= 1'b0;
            addr_o <= 26'h0000000;
            dq_o <= 16'h0000;
            dq_oe_o <= 1'b0;
            ce_n_o <= 1'b1;
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
        end else if (en_i) begin
            state_q <= state_d;
            op_q <= op_d;
            addr_q <= addr_d;
            data_q <= data_d;
            wc_q <= wc_d;
            step_q <= step_d;
            last_q <= last_d;
            tim_q <= tim_d;
            cmd_ready_o <= ready_d;
            rdata_o <= rdata_d;
            rdata_valid_o <= rvalid_d;
            addr_o <= pin_addr_d;
            dq_o <= dq_d;
            dq_oe_o <= dq_oe_d;
            ce_n_o <= ce_n_d;
            we_n_o <= we_n_d;
            oe_n_o <= oe_n_d;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i || !en_i);

    sequence s_wr(logic [fcd_pkg::AW-1:0] a, logic [fcd_pkg::DW-1:0] d);
        $fell(we_n_o) && addr_o == a && dq_o == d && dq_oe_o && !ce_n_o;
    endsequence
    sequence s_wpulse;
        !we_n_o [*5] ##1 we_n_o;
    endsequence

    AST_WE_PULSE: assert property ($fell(we_n_o) |-> s_wpulse) else $error("write pulse width wrong");
    AST_READ_DATA: assert property ($rose(rdata_valid_o) |-> $past(!oe_n_o) && rdata_o == $past(sy3_q))
        else $error("read word not taken from synchronised bus");
    AST_RESET_CMD: assert property ($fell(we_n_o) && op_q == fcd_pkg::OP_RESET |-> dq_o == fcd_pkg::D_RESET)
        else $error("reset cycle data wrong");
    AST_SR_READ: assert property ($fell(we_n_o) && op_q == fcd_pkg::OP_SR_READ
        |-> s_wr(fcd_pkg::A_UNLOCK1, fcd_pkg::D_SR_READ) ##10 $fell(oe_n_o))
        else $error("status read sequence wrong");
    AST_SR_CLEAR: assert property ($fell(we_n_o) && op_q == fcd_pkg::OP_SR_CLEAR
        |-> s_wr(fcd_pkg::A_UNLOCK1, fcd_pkg::D_SR_CLEAR) ##[8:20] cmd_ready_o)
        else $error("status clear cycle wrong");
    AST_UNLOCK: assert property ($fell(we_n_o) && step_q == 9'h000 && op_q inside {fcd_pkg::OP_PROG,
        fcd_pkg::OP_BUF_PROG, fcd_pkg::OP_BUF_ABORT, fcd_pkg::OP_CHIP_ERASE, fcd_pkg::OP_SECT_ERASE}
        |-> s_wr(fcd_pkg::A_UNLOCK1, fcd_pkg::D_UNLOCK1) ##[10:20] s_wr(fcd_pkg::A_UNLOCK2, fcd_pkg::D_UNLOCK2))
        else $error("unlock pair wrong");
    AST_PROG: assert property ($fell(we_n_o) && op_q == fcd_pkg::OP_PROG && step_q == 9'h002
        |-> s_wr(fcd_pkg::A_UNLOCK1, fcd_pkg::D_PROG) ##[10:20] s_wr(addr_q, data_q))
        else $error("word program tail wrong");
    AST_BUF_LOAD: assert property ($fell(we_n_o) && op_q == fcd_pkg::OP_BUF_PROG && step_q == 9'h002
        |-> s_wr(addr_q, fcd_pkg::D_BUF_LOAD) ##[10:20] s_wr(addr_q, fcd_pkg::DW'(wc_q - 9'h001)))
        else $error("buffer load header wrong");
    AST_BUF_CONFIRM: assert property ($fell(we_n_o) && op_q == fcd_pkg::OP_BUF_PROG && step_q == last_q
        |-> s_wr(addr_q, fcd_pkg::D_BUF_CONFIRM)) else $error("buffer confirm wrong");
    AST_ABORT: assert property ($fell(we_n_o) && op_q == fcd_pkg::OP_BUF_ABORT && step_q == 9'h002
        |-> s_wr(fcd_pkg::A_UNLOCK1, fcd_pkg::D_RESET)) else $error("abort recovery wrong");
    AST_CHIP_ERASE: assert property ($fell(we_n_o) && op_q == fcd_pkg::OP_CHIP_ERASE && step_q == 9'h005
        |-> s_wr(fcd_pkg::A_UNLOCK1, fcd_pkg::D_CHIP_ERASE)) else $error("chip erase final wrong");
    AST_SECT_ERASE: assert property ($fell(we_n_o) && op_q == fcd_pkg::OP_SECT_ERASE && step_q == 9'h005
        |-> s_wr(addr_q, fcd_pkg::D_SECT_ERASE)) else $error("sector erase final wrong");
    AST_SUSPEND: assert property ($fell(we_n_o) && op_q == fcd_pkg::OP_SUSPEND
        |-> s_wr(addr_q, fcd_pkg::D_SUSPEND)) else $error("suspend cycle wrong");
    AST_RESUME: assert property ($fell(we_n_o) && op_q == fcd_pkg::OP_RESUME
        |-> s_wr(addr_q, fcd_pkg::D_RESUME)) else $error("resume cycle wrong");
    AST_PROG_SUSPEND: assert property ($fell(we_n_o) && op_q == fcd_pkg::OP_PROG_SUSPEND
        |-> s_wr(addr_q, fcd_pkg::D_PROG_SUSPEND)) else $error("program suspend cycle wrong");
endmodule : fcd_host

// file: src/fcd_pkg.sv
package fcd_pkg;
    // flash bus geometry
    localparam int AW = 26;
    localparam int DW = 16;
    localparam int BUF_DEPTH = 256;
    localparam int BUF_AW = 8;
    localparam int CNT_W = 9;
    localparam int TIM_W = 8;
    localparam int STEP_W = 2 + AW + DW;

    // command addresses, upper bits sent as zero
    localparam logic [AW-1:0] A_UNLOCK1 = 26'h0000555;
    localparam logic [AW-1:0] A_UNLOCK2 = 26'h00002AA;

    // command data words
    localparam logic [DW-1:0] D_UNLOCK1 = 16'h00AA;
    localparam logic [DW-1:0] D_UNLOCK2 = 16'h0055;
    localparam logic [DW-1:0] D_RESET = 16'h00F0;
    localparam logic [DW-1:0] D_SR_READ = 16'h0070;
    localparam logic [DW-1:0] D_SR_CLEAR = 16'h0071;
    localparam logic [DW-1:0] D_PROG = 16'h00A0;
    localparam logic [DW-1:0] D_BUF_LOAD = 16'h0025;
    localparam logic [DW-1:0] D_BUF_CONFIRM = 16'h0029;
    localparam logic [DW-1:0] D_ERASE_SETUP = 16'h0080;
    localparam logic [DW-1:0] D_CHIP_ERASE = 16'h0010;
    localparam logic [DW-1:0] D_SECT_ERASE = 16'h0030;
    localparam logic [DW-1:0] D_SUSPEND = 16'h00B0;
    localparam logic [DW-1:0] D_RESUME = 16'h0030;
    localparam logic [DW-1:0] D_PROG_SUSPEND = 16'h0051;

    // bus timing in ns, then in 8 ns clock cycles (least times round up)
    localparam int CLK_NS = 8;
    localparam int T_WP_NS = 35;
    localparam int T_WPH_NS = 20;
    localparam int T_ACC_NS = 100;
    localparam int SYNC_LAT = 3;
    localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;

    // fixed header step count of the buffered program sequence
    localparam logic [CNT_W-1:0] BUF_HDR_STEPS = 9'h004;

    typedef enum logic [3:0] {
        OP_READ,
        OP_RESET,
        OP_SR_READ,
        OP_SR_CLEAR,
        OP_PROG,
        OP_BUF_PROG,
        OP_BUF_ABORT,
        OP_CHIP_ERASE,
        OP_SECT_ERASE,
        OP_SUSPEND,
        OP_RESUME,
        OP_PROG_SUSPEND
    } fcd_op_t;
endpackage : fcd_pkg

// file: tb/fcd_flash_model.sv
`timescale 1ns/10ps
// flash device model; writes taken at rising write strobe
module fcd_flash_model #(
    parameter int ACC_NS = 90
) (
    // flash pins
    input wire logic [fcd_pkg::AW-1:0] addr_i,
    input wire logic [fcd_pkg::DW-1:0] dq_i,
    input wire logic ce_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    output logic [fcd_pkg::DW-1:0] dq_o
);
    localparam logic [15:0] ST_READY = 16'h0080;
    localparam logic [15:0] ST_PERR = 16'h0010;
    logic [15:0] mem [logic [25:0]];
    logic [15:0] wbuf [logic [25:0]];
    logic [15:0] err = 16'h0000;
    logic [25:0] sa;
    wire a555 = addr_i == fcd_pkg::A_UNLOCK1;
    bit sr_mode = 1'b0;
    int st = 0;
    int n, k;
    int ev_code = 0;
    int ev_cnt = 0;

    function automatic logic [15:0] word(input logic [25:0] a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction : word

    task automatic note(input int c);
        ev_code = c;
        ev_cnt++;
        st = 0;
    endtask : note

    always @(posedge we_n_i) begin
        if (!ce_n_i) begin
            if (dq_i == fcd_pkg::D_RESET && !(st == 2 && a555) && st != 3 && st != 5)
                note(1);
            else case (st)
                1: st = (addr_i == fcd_pkg::A_UNLOCK2 && dq_i == fcd_pkg::D_UNLOCK2) ? 2 : 0;
                2: begin
                    if (a555 && dq_i == fcd_pkg::D_PROG) st = 3;
                    else if (dq_i == fcd_pkg::D_BUF_LOAD) begin
                        sa = addr_i;
                        st = 4;
                    end
                    else if (a555 && dq_i == fcd_pkg::D_ERASE_SETUP) st = 7;
                    else if (a555 && dq_i == fcd_pkg::D_RESET) note(5);
                    else st = 0;
                end
                3: begin
                    // cells only clear bits; setting one flags an error
                    if ((word(addr_i) & dq_i) != dq_i) err = err | ST_PERR;
                    mem[addr_i] = word(addr_i) & dq_i;
                    note(3);
                end
                4: begin
                    n = dq_i + 1;
                    k = 0;
                    wbuf.delete();
                    st = (addr_i == sa) ? 5 : 0;
                end
                5: begin
                    wbuf[addr_i] = dq_i;
                    k++;
                    if (k == n) st = 6;
                end
                6: begin
                    if (addr_i == sa && dq_i == fcd_pkg::D_BUF_CONFIRM) begin
                        foreach (wbuf[i]) mem[i] = word(i) & wbuf[i];
                        note(4);
                    end
                    else st = 0;
                end
                7: st = (a555 && dq_i == fcd_pkg::D_UNLOCK1) ? 8 : 0;
                8: st = (addr_i == fcd_pkg::A_UNLOCK2 && dq_i == fcd_pkg::D_UNLOCK2) ? 9 : 0;
                9: begin
                    if (a555 && dq_i == fcd_pkg::D_CHIP_ERASE) begin
                        mem.delete();
                        note(6);
                    end
                    else if (dq_i == fcd_pkg::D_SECT_ERASE) begin
                        foreach (mem[i]) if (i[25:16] == addr_i[25:16]) mem[i] = 16'hFFFF;
                        note(7);
                    end
                    else st = 0;
                end
                default: begin
                    if (a555 && dq_i == fcd_pkg::D_SR_READ) sr_mode = 1'b1;
                    else if (a555 && dq_i == fcd_pkg::D_SR_CLEAR) begin
                        err = 16'h0000;
                        note(2);
                    end
                    else if (a555 && dq_i == fcd_pkg::D_UNLOCK1) st = 1;
                    else if (dq_i == fcd_pkg::D_SUSPEND) note(8);
                    else if (dq_i == fcd_pkg::D_RESUME) note(9);
                    else if (dq_i == fcd_pkg::D_PROG_SUSPEND) note(10);
                end
            endcase
        end
    end

    // bus has no pull: idle lines show garbage
    always @(ce_n_i or oe_n_i or addr_i) begin
        dq_o = ~dq_o;
        if (!ce_n_i && !oe_n_i) dq_o <= #(ACC_NS) sr_mode ? (ST_READY | err) : word(addr_i);
    end

    always @(posedge oe_n_i) sr_mode = 1'b0;
endmodule : fcd_flash_model

// file: tb/fcd_host_bench.sv
`timescale 1ns/10ps
module fcd_host_bench;
    typedef struct {
        fcd_pkg::fcd_op_t op;
        logic [25:0] addr;
        int ev;
        logic [15:0] w;
    } fcd_row_t;
    logic clk_i, nrst_i, cmd_valid_i, cmd_ready_o, rdata_valid_o, buf_we_i, dq_oe_o, ce_n_o, we_n_o, oe_n_o;
    fcd_pkg::fcd_op_t cmd_op_i;
    logic [25:0] cmd_addr_i, addr_o;
    logic [15:0] cmd_data_i, rdata_o, buf_wdata_i, dq_o, flash_dq, dq_w, got;
    logic [8:0] cmd_count_i;
    logic [7:0] buf_idx_i;
    int bad_count = 0;
    int n_tests = 0;
    int e0;
    // w is the program word, or for ev -1 the word read back
    fcd_row_t rows [0:17] = '{
        '{fcd_pkg::OP_CHIP_ERASE, 26'h0000000, 6, 16'h0000},
        '{fcd_pkg::OP_READ, 26'h0000100, -1, 16'hFFFF},
        '{fcd_pkg::OP_PROG, 26'h0000100, 3, 16'h1234},
        '{fcd_pkg::OP_READ, 26'h0000100, -1, 16'h1234},
        '{fcd_pkg::OP_PROG, 26'h0010005, 3, 16'h0000},
        '{fcd_pkg::OP_SECT_ERASE, 26'h0010000, 7, 16'h0000},
        '{fcd_pkg::OP_READ, 26'h0010005, -1, 16'hFFFF},
        '{fcd_pkg::OP_READ, 26'h0000100, -1, 16'h1234},
        '{fcd_pkg::OP_PROG, 26'h0000100, 3, 16'hFFFF},
        '{fcd_pkg::OP_SR_READ, 26'h0000007, -1, 16'h0090},
        '{fcd_pkg::OP_READ, 26'h0000100, -1, 16'h1234},
        '{fcd_pkg::OP_SR_CLEAR, 26'h0000000, 2, 16'h0000},
        '{fcd_pkg::OP_SR_READ, 26'h0000000, -1, 16'h0080},
        '{fcd_pkg::OP_SUSPEND, 26'h0000033, 8, 16'h0000},
        '{fcd_pkg::OP_RESUME, 26'h0000044, 9, 16'h0000},
        '{fcd_pkg::OP_PROG_SUSPEND, 26'h0000055, 10, 16'h0000},
        '{fcd_pkg::OP_RESET, 26'h0000066, 1, 16'h0000},
        '{fcd_pkg::OP_BUF_ABORT, 26'h0000000, 5, 16'h0000}
    };

    assign dq_w = dq_oe_o ? dq_o : flash_dq;

    fcd_host fcd_host_i (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(1'b1), .cmd_valid_i(cmd_valid_i),
        .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i), .cmd_count_i(cmd_count_i),
        .cmd_ready_o(cmd_ready_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .buf_we_i(buf_we_i),
        .buf_idx_i(buf_idx_i), .buf_wdata_i(buf_wdata_i), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
        .dq_i(dq_w), .ce_n_o(ce_n_o), .we_n_o(we_n_o), .oe_n_o(oe_n_o));

    fcd_flash_model fcd_flash_model_i (.addr_i(addr_o), .dq_i(dq_w), .ce_n_i(ce_n_o), .we_n_i(we_n_o),
        .oe_n_i(oe_n_o), .dq_o(flash_dq));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [15:0] exp, seen);
        n_tests++;
        if (exp !== seen) begin
            $display("unexpected %s expected %h seen %h", what, exp, seen);
            bad_count++;
        end
    endtask : check

    // bounded wait for ready
    task automatic do_cmd(input fcd_pkg::fcd_op_t op, input logic [25:0] a, input logic [15:0] d,
                          input logic [8:0] n);
        int i;
        got = 16'hXXXX;
        @(posedge clk_i);
        cmd_valid_i <= 1'b1;
        cmd_op_i <= op;
        cmd_addr_i <= a;
        cmd_data_i <= d;
        cmd_count_i <= n;
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        for (i = 0; i < 5000; i++) begin
            @(posedge clk_i);
            #1;
            if (rdata_valid_o === 1'b1) got = rdata_o;
            if (cmd_ready_o === 1'b1) break;
        end
        if (i == 5000) begin
            $display("unexpected ready wait expected 1 seen 0");
            bad_count++;
            print_verdict();
        end
    endtask : do_cmd

    initial begin
        nrst_i = 1'b0;
        cmd_valid_i = 1'b0;
        cmd_op_i = fcd_pkg::OP_READ;
        cmd_addr_i = 26'h0000000;
        cmd_data_i = 16'h0000;
        cmd_count_i = 9'h001;
        buf_we_i = 1'b0;
        buf_idx_i = 8'h00;
        buf_wdata_i = 16'h0000;
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        foreach (rows[i]) begin
            e0 = fcd_flash_model_i.ev_cnt;
            do_cmd(rows[i].op, rows[i].addr, rows[i].w, 9'h001);
            if (rows[i].ev < 0) check("read word", rows[i].w, got);
            else check("command", 16'(rows[i].ev), 16'(fcd_flash_model_i.ev_code));
            check("command count", 16'(e0 + int'(rows[i].ev >= 0)), 16'(fcd_flash_model_i.ev_cnt));
        end
        // full 256-word buffer
        for (int i = 0; i < 256; i++) begin
            @(posedge clk_i);
            buf_we_i <= 1'b1;
            buf_idx_i <= 8'(i);
            buf_wdata_i <= {8'hC3, 8'(i)};
        end
        @(posedge clk_i);
        buf_we_i <= 1'b0;
        do_cmd(fcd_pkg::OP_BUF_PROG, 26'h0020000, 16'h0000, 9'h100);
        check("buffer program", 16'h0004, 16'(fcd_flash_model_i.ev_code));
        for (int i = 0; i < 256; i += 255) begin
            do_cmd(fcd_pkg::OP_READ, 26'h0020000 + 26'(i), 16'h0000, 9'h001);
            check("buffer word", {8'hC3, 8'(i)}, got);
        end
        // mid-sequence reset; a reset command must clear the device
        @(posedge clk_i);
        cmd_valid_i <= 1'b1;
        cmd_op_i <= fcd_pkg::OP_PROG;
        cmd_addr_i <= 26'h0000200;
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        repeat (14) @(posedge clk_i);
        nrst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check("strobes in reset", 16'h0007, {13'h0000, ce_n_o, we_n_o, oe_n_o});
        check("ready oe in reset", 16'h0002, {14'h0000, cmd_ready_o, dq_oe_o});
        check("rdata in reset", 16'h0000, rdata_o);
        repeat (9) @(posedge clk_i);
        nrst_i <= 1'b1;
        do_cmd(fcd_pkg::OP_RESET, 26'h0000000, 16'h0000, 9'h001);
        check("reset after abandon", 16'h0001, 16'(fcd_flash_model_i.ev_code));
        do_cmd(fcd_pkg::OP_READ, 26'h0000200, 16'h0000, 9'h001);
        check("unprogrammed word", 16'hFFFF, got);
        print_verdict();
    end
endmodule : fcd_host_bench
